/* hdl/ars_pkg.sv */
/*
  Shared types and constants for the unattended read sequencer.
  Assumes a 50 MHz system clock; used by the sequencer and its bench.
*/
package ars_pkg;

  localparam int unsigned CLK_HZ        = 50000000;
  localparam int unsigned TICK_MS_PER_S = 1000;
  // Cycles per millisecond tick
  localparam int unsigned MS_CYCLES     = CLK_HZ / 1000;
  localparam int unsigned PRESC_W       = 16;
  localparam int unsigned MS_W          = 16;
  localparam int unsigned PERIOD_W      = 16;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_EDGES   = 8'h04;
  localparam logic [7:0] OFS_OUTVAL  = 8'h08;
  localparam logic [7:0] OFS_WORKMS  = 8'h0C;
  localparam logic [7:0] OFS_HOLDMS  = 8'h10;
  localparam logic [7:0] OFS_PERIOD  = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;

  // Reset values
  localparam logic [31:0] RST_CTRL   = 32'h0000_0000;
  localparam logic [31:0] RST_EDGES  = 32'h0000_0000;
  localparam logic [31:0] RST_OUTVAL = 32'h0000_0000;
  localparam logic [31:0] RST_WORKMS = 32'h0000_0000;
  localparam logic [31:0] RST_HOLDMS = 32'h0000_0000;
  localparam logic [31:0] RST_PERIOD = 32'h0000_0000;

  // CTRL field positions
  localparam int unsigned CTRL_UNATT  = 0;
  localparam int unsigned CTRL_ACQ    = 1;
  localparam int unsigned CTRL_REPEN  = 2;
  localparam int unsigned CTRL_LAYOUT = 3;
  localparam int unsigned CTRL_COND   = 4;
  localparam int unsigned CTRL_DEST   = 8;

  typedef enum logic [2:0]
  {
    COND_ADD    = 3'h0,
    COND_REMOVE = 3'h1,
    COND_CHANGE = 3'h2,
    COND_TRUE   = 3'h3,
    COND_FALSE  = 3'h4
  } ars_cond_e;

  typedef enum logic [1:0]
  {
    DEST_MAIL   = 2'h0,
    DEST_HOST   = 2'h1,
    DEST_SERIAL = 2'h2
  } ars_dest_e;

  typedef enum logic [2:0]
  {
    ST_OFF    = 3'h0,
    ST_WAIT   = 3'h1,
    ST_WORK   = 3'h2,
    ST_EVAL   = 3'h3,
    ST_HOLD   = 3'h4,
    ST_NOTIFY = 3'h5
  } ars_state_e;

  // Edge pattern: rising and falling masks
  typedef struct packed
  {
    logic [1:0] rise;
    logic [1:0] fall;
  } ars_pat_s;

  // Tag-list events from the acquisition engine
  typedef struct packed
  {
    logic added;
    logic removed;
  } ars_tagev_s;

  // Notification request to the transport
  typedef struct packed
  {
    logic      periodic;
    logic      layout_xml;
    ars_dest_e dest;
  } ars_note_s;

endpackage

/* hdl/ars_edge.sv */
/*
  Input front end: two-stage synchroniser and edge detector for two lines.
  Assumes pins are asynchronous to CLK_SYS.
*/
`timescale 1ns/1ns
`default_nettype none
module ars_edge
(
  input  wire logic       CLK_SYS,
  input  wire logic       RESETN,
  input  wire logic [1:0] PIN_IN,
  output logic      [1:0] RISE,
  output logic      [1:0] FALL
);

  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] prev_reg;
  logic [1:0] sync1_next;
  logic [1:0] sync2_next;
  logic [1:0] prev_next;

  always_comb
  begin
    sync1_next = PIN_IN;
    sync2_next = sync1_reg;
    prev_next  = sync2_reg;
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
      prev_reg  <= 2'h0;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg  <= prev_next;
    end
  end

  // Compare synchronised sample with previous one
  assign RISE = sync2_reg & ~prev_reg;
  assign FALL = ~sync2_reg & prev_reg;

endmodule
`default_nettype wire

/* hdl/ars_seq.sv */
/*
  Unattended read sequencer with AXI4-Lite configuration slave.
  Assumes an acquisition engine reports tag-list add and remove events
  (already filtered by retention) and a transport takes notifications.
*/
`timescale 1ns/1ns
`default_nettype none
module ars_seq
#(
  parameter int unsigned MS_CYCLES = ars_pkg::MS_CYCLES
)
(
  input  wire logic               CLK_SYS,
  input  wire logic               RESETN,
  input  wire logic [7:0]         S_AXI_AWADDR,
  input  wire logic               S_AXI_AWVALID,
  output logic                    S_AXI_AWREADY,
  input  wire logic [31:0]        S_AXI_WDATA,
  input  wire logic [3:0]         S_AXI_WSTRB,
  input  wire logic               S_AXI_WVALID,
  output logic                    S_AXI_WREADY,
  output logic [1:0]              S_AXI_BRESP,
  output logic                    S_AXI_BVALID,
  input  wire logic               S_AXI_BREADY,
  input  wire logic [7:0]         S_AXI_ARADDR,
  input  wire logic               S_AXI_ARVALID,
  output logic                    S_AXI_ARREADY,
  output logic [31:0]             S_AXI_RDATA,
  output logic [1:0]              S_AXI_RRESP,
  output logic                    S_AXI_RVALID,
  input  wire logic               S_AXI_RREADY,
  input  wire logic [1:0]         PIN_IN,
  output logic [1:0]              PIN_OUT,
  input  wire ars_pkg::ars_tagev_s TAG_EV,
  output logic                    ACQ_REQ,
  output logic                    NOTE_REQ,
  output var ars_pkg::ars_note_s  NOTE_INFO,
  input  wire logic               NOTE_DONE,
  output logic                    UNATT_ACTIVE
);

  logic [31:0] ctrl_reg, edges_reg, outval_reg, workms_reg, holdms_reg, period_reg;
  logic [31:0] ctrl_next, edges_next, outval_next, workms_next, holdms_next, period_next;
  logic        aw_reg, w_reg, bv_reg, rv_reg;
  logic        aw_next, w_next, bv_next, rv_next;
  logic [7:0]  awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
  logic [1:0]  br_reg, br_next, rr_reg, rr_next;

  ars_pkg::ars_state_e st_reg, st_next;
  logic [ars_pkg::PRESC_W-1:0] pre_reg, pre_next;
  logic [ars_pkg::MS_W-1:0]    ms_reg, ms_next;
  logic [ars_pkg::PERIOD_W-1:0] per_reg, per_next;
  logic [9:0]  sec_reg, sec_next;
  logic [1:0]  seen_reg, seen_next, out_reg, out_next;
  logic        added_reg, added_next, removed_reg, removed_next, hit_reg, hit_next;
  logic        note_reg, note_next, force_reg, force_next;
  ars_pkg::ars_note_s info_reg, info_next;
  logic [1:0]  rise, fall;
  logic        tick, wr_go, unatt;
  ars_pkg::ars_pat_s start_pat, stop_pat;

  ars_edge u_edge
  (
    .CLK_SYS (CLK_SYS),
    .RESETN  (RESETN),
    .PIN_IN  (PIN_IN),
    .RISE    (rise),
    .FALL    (fall)
  );

  // Mask matching; accumulates edges until all selected pins have seen one
  function automatic logic [1:0] pat_seen(ars_pkg::ars_pat_s p, logic [1:0] r,
                                           logic [1:0] f, logic [1:0] acc);
    pat_seen = acc | (p.rise & r) | (p.fall & f);
  endfunction

  function automatic logic pat_done(ars_pkg::ars_pat_s p, logic [1:0] s);
    logic [1:0] m;
    m = p.rise | p.fall;
    pat_done = (m != 2'h0) && ((s & m) == m);
  endfunction

  assign start_pat = edges_reg[3:0];
  assign stop_pat  = edges_reg[11:8];
  assign unatt     = ctrl_reg[ars_pkg::CTRL_UNATT];
  assign tick      = (pre_reg == ars_pkg::PRESC_W'(MS_CYCLES - 1));

  // AXI4-Lite slave
  assign wr_go = aw_reg && w_reg && !bv_reg;
  always_comb
  begin
    aw_next = aw_reg; w_next = w_reg; awa_next = awa_reg; wd_next = wd_reg;
    bv_next = bv_reg; br_next = br_reg; rv_next = rv_reg; rr_next = rr_reg;
    rd_next = rd_reg;
    ctrl_next = ctrl_reg; edges_next = edges_reg; outval_next = outval_reg;
    workms_next = workms_reg; holdms_next = holdms_reg; period_next = period_reg;
    if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      aw_next = 1'b1; awa_next = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      w_next = 1'b1; wd_next = S_AXI_WDATA;
    end
    if (wr_go)
    begin
      aw_next = 1'b0; w_next = 1'b0; bv_next = 1'b1; br_next = 2'h0;
      case (awa_reg)
        ars_pkg::OFS_CTRL:   ctrl_next   = wd_reg;
        ars_pkg::OFS_EDGES:  edges_next  = wd_reg;
        ars_pkg::OFS_OUTVAL: outval_next = wd_reg;
        ars_pkg::OFS_WORKMS: workms_next = wd_reg;
        ars_pkg::OFS_HOLDMS: holdms_next = wd_reg;
        ars_pkg::OFS_PERIOD: period_next = wd_reg;
        default:             br_next     = 2'h2;
      endcase
    end
    if (bv_reg && S_AXI_BREADY)
      bv_next = 1'b0;
    if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      rv_next = 1'b1; rr_next = 2'h0;
      case (S_AXI_ARADDR)
        ars_pkg::OFS_CTRL:   rd_next = ctrl_reg;
        ars_pkg::OFS_EDGES:  rd_next = edges_reg;
        ars_pkg::OFS_OUTVAL: rd_next = outval_reg;
        ars_pkg::OFS_WORKMS: rd_next = workms_reg;
        ars_pkg::OFS_HOLDMS: rd_next = holdms_reg;
        ars_pkg::OFS_PERIOD: rd_next = period_reg;
        ars_pkg::OFS_STATUS: rd_next = {22'h0, hit_reg, removed_reg, added_reg,
                                        out_reg, 2'h0, st_reg};
        default:
        begin
          rd_next = 32'h0; rr_next = 2'h2;
        end
      endcase
    end
    if (rv_reg && S_AXI_RREADY)
      rv_next = 1'b0;
  end
  assign S_AXI_AWREADY = !aw_reg;
  assign S_AXI_WREADY  = !w_reg;
  assign S_AXI_BVALID  = bv_reg;
  assign S_AXI_BRESP   = br_reg;
  assign S_AXI_ARREADY = !rv_reg;
  assign S_AXI_RVALID  = rv_reg;
  assign S_AXI_RDATA   = rd_reg;
  assign S_AXI_RRESP   = rr_reg;

  // Sequencer
  always_comb
  begin
    st_next = st_reg; pre_next = tick ? '0 : pre_reg + 1'b1;
    ms_next = ms_reg; seen_next = seen_reg; out_next = out_reg;
    hit_next = hit_reg; note_next = 1'b0; info_next = info_reg;
    added_next = added_reg | TAG_EV.added;
    removed_next = removed_reg | TAG_EV.removed;
    per_next = per_reg; sec_next = sec_reg; force_next = force_reg;
    if (period_reg[ars_pkg::PERIOD_W-1:0] != '0 && tick)
    begin
      sec_next = (sec_reg == 10'(ars_pkg::TICK_MS_PER_S - 1)) ? 10'h0 : sec_reg + 10'h1;
      if (sec_reg == 10'(ars_pkg::TICK_MS_PER_S - 1))
      begin
        per_next = per_reg + 1'b1;
        if (per_reg + 1'b1 >= period_reg[ars_pkg::PERIOD_W-1:0])
        begin
          per_next = '0; force_next = 1'b1;
        end
      end
    end
    case (st_reg)
      ars_pkg::ST_OFF:
      begin
        out_next = 2'h0;
        if (unatt)
        begin
          st_next = ars_pkg::ST_WAIT; seen_next = 2'h0;
          out_next = outval_reg[1:0];
        end
      end
      ars_pkg::ST_WAIT:
      begin
        out_next = outval_reg[1:0];
        seen_next = pat_seen(start_pat, rise, fall, seen_reg);
        if (start_pat == '0 || pat_done(start_pat, seen_next))
        begin
          st_next = ars_pkg::ST_WORK; seen_next = 2'h0;
          ms_next = workms_reg[ars_pkg::MS_W-1:0];
          out_next = outval_reg[9:8];
        end
      end
      ars_pkg::ST_WORK:
      begin
        seen_next = pat_seen(stop_pat, rise, fall, seen_reg);
        if (tick && ms_reg != '0)
          ms_next = ms_reg - 1'b1;
        if (pat_done(stop_pat, seen_next) ||
            (workms_reg[ars_pkg::MS_W-1:0] != '0 && tick && ms_reg == 16'h1))
          st_next = ars_pkg::ST_EVAL;
      end
      ars_pkg::ST_EVAL:
      begin
        hit_next = added_reg;
        st_next = ars_pkg::ST_HOLD;
        out_next = added_reg ? outval_reg[17:16] : outval_reg[25:24];
        ms_next = added_reg ? holdms_reg[15:0] : holdms_reg[31:16];
      end
      ars_pkg::ST_HOLD:
      begin
        if (ms_reg == '0)
          st_next = ars_pkg::ST_NOTIFY;
        else if (tick)
          ms_next = ms_reg - 1'b1;
      end
      ars_pkg::ST_NOTIFY:
      begin
        st_next = ars_pkg::ST_WAIT;
        added_next = TAG_EV.added; removed_next = TAG_EV.removed;
      end
      default: st_next = ars_pkg::ST_OFF;
    endcase
    if (st_reg == ars_pkg::ST_NOTIFY && ctrl_reg[ars_pkg::CTRL_REPEN])
    begin
      case (ars_pkg::ars_cond_e'(ctrl_reg[ars_pkg::CTRL_COND +: 3]))
        ars_pkg::COND_ADD:    note_next = added_reg;
        ars_pkg::COND_REMOVE: note_next = removed_reg;
        ars_pkg::COND_CHANGE: note_next = added_reg | removed_reg;
        ars_pkg::COND_TRUE:   note_next = hit_reg;
        ars_pkg::COND_FALSE:  note_next = !hit_reg;
        default:              note_next = 1'b0;
      endcase
    end
    if (force_reg && ctrl_reg[ars_pkg::CTRL_REPEN] && unatt && !note_next)
    begin
      note_next = 1'b1; force_next = 1'b0;
    end
    if (note_next)
    begin
      info_next.periodic   = !(st_reg == ars_pkg::ST_NOTIFY) || force_reg;
      info_next.layout_xml = ctrl_reg[ars_pkg::CTRL_LAYOUT];
      info_next.dest = ars_pkg::ars_dest_e'(ctrl_reg[ars_pkg::CTRL_DEST +: 2]);
    end
    if (!unatt)
    begin
      st_next = ars_pkg::ST_OFF; note_next = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      aw_reg <= 1'b0; w_reg <= 1'b0; bv_reg <= 1'b0; rv_reg <= 1'b0;
      awa_reg <= 8'h00; wd_reg <= 32'h0; rd_reg <= 32'h0;
      br_reg <= 2'h0; rr_reg <= 2'h0;
      ctrl_reg <= ars_pkg::RST_CTRL; edges_reg <= ars_pkg::RST_EDGES;
      outval_reg <= ars_pkg::RST_OUTVAL; workms_reg <= ars_pkg::RST_WORKMS;
      holdms_reg <= ars_pkg::RST_HOLDMS; period_reg <= ars_pkg::RST_PERIOD;
      st_reg <= ars_pkg::ST_OFF; pre_reg <= '0; ms_reg <= '0;
      seen_reg <= 2'h0; out_reg <= 2'h0; hit_reg <= 1'b0;
      added_reg <= 1'b0; removed_reg <= 1'b0; note_reg <= 1'b0;
      info_reg <= '0; per_reg <= '0; sec_reg <= 10'h0; force_reg <= 1'b0;
    end
    else
    begin
      aw_reg <= aw_next; w_reg <= w_next; bv_reg <= bv_next; rv_reg <= rv_next;
      awa_reg <= awa_next; wd_reg <= wd_next; rd_reg <= rd_next;
      br_reg <= br_next; rr_reg <= rr_next;
      ctrl_reg <= ctrl_next; edges_reg <= edges_next; outval_reg <= outval_next;
      workms_reg <= workms_next; holdms_reg <= holdms_next; period_reg <= period_next;
      st_reg <= st_next; pre_reg <= pre_next; ms_reg <= ms_next;
      seen_reg <= seen_next; out_reg <= out_next; hit_reg <= hit_next;
      added_reg <= added_next; removed_reg <= removed_next; note_reg <= note_next;
      info_reg <= info_next; per_reg <= per_next; sec_reg <= sec_next;
      force_reg <= force_next;
    end
  end

  assign PIN_OUT      = out_reg;
  assign ACQ_REQ      = (st_reg == ars_pkg::ST_WORK) && ctrl_reg[ars_pkg::CTRL_ACQ];
  assign NOTE_REQ     = note_reg;
  assign NOTE_INFO    = info_reg;
  assign UNATT_ACTIVE = (st_reg != ars_pkg::ST_OFF);

  a_wait_to_work: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (st_reg == ars_pkg::ST_WAIT && start_pat == '0 && unatt) |=> st_reg == ars_pkg::ST_WORK)
    else $error("zero start pattern did not enter work");
  a_work_output: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (st_reg == ars_pkg::ST_WORK) |-> PIN_OUT == outval_reg[9:8])
    else $error("work output value wrong");
  a_eval_hold: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (st_reg == ars_pkg::ST_EVAL && unatt) |=> (st_reg == ars_pkg::ST_HOLD &&
     PIN_OUT == ($past(added_reg) ? outval_reg[17:16] : outval_reg[25:24])))
    else $error("hold output wrong");
  a_disable_off: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    !unatt |=> st_reg == ars_pkg::ST_OFF)
    else $error("sequence not left on disable");
  a_notify_back: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (st_reg == ars_pkg::ST_NOTIFY && unatt) |=> st_reg == ars_pkg::ST_WAIT)
    else $error("no return to waiting");
  a_note_gate: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    $rose(NOTE_REQ) |-> $past(ctrl_reg[ars_pkg::CTRL_REPEN]))
    else $error("report issued while disabled");
  a_acq_hold: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (ACQ_REQ && unatt && !wr_go && !tick && !pat_done(stop_pat, seen_next)) |=> ACQ_REQ)
    else $error("acquisition stopped before a stop condition");
  a_enter_wait: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (st_reg == ars_pkg::ST_OFF && unatt) |=> (st_reg == ars_pkg::ST_WAIT &&
     PIN_OUT == outval_reg[1:0]))
    else $error("enable did not enter waiting");

endmodule
`default_nettype wire

/* bench/ars_trig_src.sv */
/*
  Behavioural trigger source, such as a photo-eye, on the two input lines.
  Assumes the bench calls pulse; the rising edge lands 7 ns after the call and the falling edge width_ns later, off the clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module ars_trig_src
(
  output var logic [1:0] pin_lines
);
  initial pin_lines = 2'h0;

  // Lines idle low; a pulse gives a rising then a falling edge on each masked line
  task automatic pulse(input logic [1:0] m, input int width_ns);
    #7;
    pin_lines = pin_lines | m;
    #(width_ns);
    pin_lines = pin_lines & ~m;
  endtask
endmodule
`default_nettype wire

/* bench/tb_autonomous_read_sequencer.sv */
/*
  Self-checking bench for the unattended read sequencer over AXI4-Lite.
  Assumes the design's ars_seq top with a shortened millisecond prescaler.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_autonomous_read_sequencer;
  localparam int MS = 10;
  logic clk_sys, resetn, awvalid, wvalid, bready, arvalid, rready, note_done;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rd, seed;
  logic [3:0]  wstrb;
  logic [1:0]  resp, pin_out, pin_in, d;
  logic        awready, wready, bvalid, arready, rvalid, acq_req, note_req, unatt;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        a, r, lay, rep;
  ars_pkg::ars_tagev_s tag_ev;
  ars_pkg::ars_note_s  note_info, info;
  int mismatches, num_checks, cycles, n, cv, notes;

  ars_seq #(.MS_CYCLES(MS)) dut (.CLK_SYS(clk_sys), .RESETN(resetn),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .TAG_EV(tag_ev), .ACQ_REQ(acq_req), .NOTE_REQ(note_req),
    .NOTE_INFO(note_info), .NOTE_DONE(note_done), .UNATT_ACTIVE(unatt));
  ars_trig_src trig (.pin_lines(pin_in));

  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) note_done <= note_req;
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      mismatches++;
      stop_test();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected notification for a report condition
  function automatic logic note_exp(input logic [2:0] c, input logic ad, input logic rm);
    case (c)
      3'h0: return ad;
      3'h1: return rm;
      3'h2: return ad | rm;
      3'h3: return ad;
      3'h4: return !ad;
      default: return 1'b0;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi)
    begin
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      mismatches++;
    end
  endtask

  // Waits for the answer however long it takes; only the timeout ends a hang
  task automatic axw(input logic [7:0] ad, input logic [31:0] dt);
    int i;
    i = 0;
    awaddr <= ad;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      i++;
      if (awready === 1'b1 && awvalid) awvalid <= 1'b0;
      if (wready === 1'b1 && wvalid) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    resp = bresp;
    chk("write answer cycles", 32'h3, 32'(i));
  endtask

  task automatic axr(input logic [7:0] ad);
    int i;
    i = 0;
    araddr <= ad;
    arvalid <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      i++;
      if (arready === 1'b1 && arvalid) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    resp = rresp;
    rd = rdata;
    chk("read answer cycles", 32'h2, 32'(i));
  endtask

  task automatic wait_acq(input logic v, input int bound);
    n = 0;
    while (acq_req !== v && n < bound)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk("acq_req", {31'h0, v}, {31'h0, acq_req});
  endtask

  // Counts cycles showing value v on the output lines, and notification pulses
  task automatic watch(input int len, input logic [1:0] v);
    cv = 0;
    notes = 0;
    repeat (len)
    begin
      @(posedge clk_sys);
      if (pin_out === v) cv++;
      if (note_req === 1'b1)
      begin
        notes++;
        info = note_info;
      end
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    {awvalid, wvalid, arvalid} = '0;
    // Response ready held high, so back-to-back tasks never toggle it
    {bready, rready} = 2'h3;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    tag_ev = '0;
    seed = 32'h7c4c5fc3;
    {mismatches, num_checks, cycles} = '0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    for (int k = 0; k < 6; k++)
    begin
      axr(8'(4 * k));
      chk("reset value", 32'h0, rd);
    end
    axr(8'h1C);
    chk("unmapped read resp", 32'h2, {30'h0, resp});
    axw(8'h1C, 32'h0000_0001);
    chk("unmapped write resp", 32'h2, {30'h0, resp});
    chk("unatt after reset", 32'h0, {31'h0, unatt});
    // Triggered run: start on rise of pin two, stop on rise of pin one
    axw(ars_pkg::OFS_OUTVAL, 32'h0201_0303);
    axr(ars_pkg::OFS_OUTVAL);
    chk("outval", 32'h0201_0303, rd);
    axw(ars_pkg::OFS_HOLDMS, 32'h0002_0002);
    axw(ars_pkg::OFS_WORKMS, 32'h0);
    axw(ars_pkg::OFS_EDGES, 32'h0000_0408);
    axw(ars_pkg::OFS_CTRL, 32'h0000_023F);
    repeat (4) @(posedge clk_sys);
    chk("unatt on", 32'h1, {31'h0, unatt});
    chk("idle out", 32'h3, {30'h0, pin_out});
    axr(ars_pkg::OFS_STATUS);
    chk("state wait", 32'(ars_pkg::ST_WAIT), {29'h0, rd[2:0]});
    trig.pulse(2'h1, 200);
    repeat (10) @(posedge clk_sys);
    chk("no start on pin one", 32'h0, {31'h0, acq_req});
    trig.pulse(2'h2, 200);
    wait_acq(1'b1, 20);
    chk("work out", 32'h3, {30'h0, pin_out});
    @(posedge clk_sys);
    tag_ev <= '{added: 1'b1, removed: 1'b0};
    @(posedge clk_sys);
    tag_ev <= '0;
    repeat (30) @(posedge clk_sys);
    chk("no timer keeps working", 32'h1, {31'h0, acq_req});
    // Short stop pulse so the watch below sees the whole hold
    trig.pulse(2'h1, 40);
    wait_acq(1'b0, 20);
    watch(40, 2'h1);
    chk_rng("hit hold", MS, 2 * MS + 5, cv);
    chk("notes", 32'h1, 32'(notes));
    chk("note info", 32'h6, 32'(info));
    chk("back to idle", 32'h3, {30'h0, pin_out});
    // Free-running loops, one per report condition
    for (int c = 0; c < 5; c++)
    begin
      axw(ars_pkg::OFS_CTRL, 32'h0);
      repeat (4) @(posedge clk_sys);
      chk("unatt off", 32'h0, {31'h0, unatt});
      chk("acq off", 32'h0, {31'h0, acq_req});
      axw(ars_pkg::OFS_EDGES, 32'h0);
      axw(ars_pkg::OFS_WORKMS, 32'h4);
      a = rnd() % 2;
      r = rnd() % 2;
      lay = rnd() % 2;
      rep = rnd() % 2;
      d = 2'(rnd() % 3);
      axw(ars_pkg::OFS_CTRL, {22'h0, d, 1'b0, 3'(c), lay, rep, 2'h3});
      wait_acq(1'b1, 12);
      @(posedge clk_sys);
      tag_ev <= '{added: a, removed: r};
      @(posedge clk_sys);
      tag_ev <= '0;
      wait_acq(1'b0, 80);
      chk_rng("work time", 3 * MS, 4 * MS + 5, n + 2);
      watch(42, a ? 2'h1 : 2'h2);
      chk_rng("eval hold", MS, 2 * MS + 5, cv);
      chk("note decision", {31'h0, rep & note_exp(3'(c), a, r)}, 32'(notes));
      if (notes == 1)
        chk("note info", {28'h0, 1'b0, lay, d}, 32'(info));
    end
    // Periodic report while waiting for a start edge
    axw(ars_pkg::OFS_CTRL, 32'h0);
    axw(ars_pkg::OFS_EDGES, 32'h0000_0008);
    axw(ars_pkg::OFS_PERIOD, 32'h1);
    axw(ars_pkg::OFS_CTRL, 32'h0000_0005);
    watch(1000 * MS + 60, 2'h0);
    chk("periodic notes", 32'h1, 32'(notes));
    chk("periodic flag", 32'h1, {31'h0, info.periodic});
    stop_test();
  end
endmodule
`default_nettype wire
